// >>> src/pss_pkg.sv
`default_nettype none
package pss_pkg;

    // ====================================================================
    // register indexes (byte address is four times the index)
    localparam logic [5:0] PSS_IDX_CMD    = 6'h0D;
    localparam logic [5:0] PSS_IDX_WINDOW = 6'h0E;
    localparam logic [5:0] PSS_IDX_CAUSE  = 6'h0F;
    localparam logic [5:0] PSS_IDX_SUMM   = 6'h10;

    // ====================================================================
    // command register fields
    localparam int         PSS_CMD_MSB     = 15;
    localparam int         PSS_CMD_LSB     = 14;
    localparam int         PSS_SEL_MSB     = 4;
    localparam logic [1:0] PSS_CMD_ADDR    = 2'h0;
    localparam logic [1:0] PSS_CMD_DATA    = 2'h1;
    localparam logic [1:0] PSS_CMD_INC_RW  = 2'h2;
    localparam logic [1:0] PSS_CMD_INC_WR  = 2'h3;
    localparam logic [4:0] PSS_SEL_VENDOR  = 5'h1F;
    localparam logic [4:0] PSS_SEL_DEV3    = 5'h03;
    localparam logic [4:0] PSS_SEL_DEV7    = 5'h07;

    // ====================================================================
    // link drop cause field positions
    localparam int PSS_FLD_DESYNC = 8;
    localparam int PSS_FLD_RXERR  = 7;
    localparam int PSS_FLD_MLT3   = 6;
    localparam int PSS_FLD_SNR    = 5;
    localparam int PSS_FLD_ENERGY = 4;

    // ====================================================================
    // summary status field positions
    localparam int PSS_ST_MDIX   = 14;
    localparam int PSS_ST_RXERR  = 13;
    localparam int PSS_ST_POL    = 12;
    localparam int PSS_ST_FCAR   = 11;
    localparam int PSS_ST_SIGDET = 10;
    localparam int PSS_ST_DLOCK  = 9;
    localparam int PSS_ST_PAGE   = 8;
    localparam int PSS_ST_IRQ    = 7;
    localparam int PSS_ST_RFAULT = 6;
    localparam int PSS_ST_JAB    = 5;
    localparam int PSS_ST_AN     = 4;
    localparam int PSS_ST_LOOP   = 3;
    localparam int PSS_ST_DUPLEX = 2;
    localparam int PSS_ST_SPEED  = 1;
    localparam int PSS_ST_LINK   = 0;

    // ====================================================================
    // reset values
    localparam logic [15:0] PSS_RST_WINDOW = 16'h0000;
    localparam logic [4:0]  PSS_RST_CAUSE  = 5'h00;
    localparam logic        PSS_RST_SPEED  = 1'b1;

endpackage
`default_nettype wire

// >>> src/pss_regs.sv
// Functional notes
// (R01) window holds target address when command is 00, otherwise target data
// (R02) command 00 address, 01 data, 10 increment on rd/wr, 11 increment on wr
// (R03) selector 11111, 00011, 00111 valid; other selectors ignore window accesses (window reads with command 00 still return the address)
// (R04) cause bits 8..4 latch high when an enabled fast drop fires
// (R05) reading cause register clears bits unless their condition still present
// (R06) bit 14 shows current crossover state
// (R07) bit 13 latches receive errors, cleared by receive error counter read
// (R08) bit 12 latches inverted polarity, cleared by ten meg status read only
// (R09) bit 11 latches false carrier, cleared by false carrier counter read
// (R10) bit 10 signal detect, latch low; ignored during low power idle (no low power idle input here; the latch is never suspended)
// (R11) bit 9 descrambler lock, latch low; ignored during low power idle (no low power idle input here; the latch is never suspended)
// (R12) latch-low bits stay zero until summary read, then follow live value
// (R13) bit 8 copies page received, cleared by expansion register read
// (R14) bit 7 set on pending interrupt, cleared by interrupt status read
// (R15) bit 6 remote fault latched, cleared by basic status read or reset
// (R16) bit 5 mirrors jabber flag, not cleared by summary read
// (R17) bit 4 shows auto-negotiation complete
// (R18) bit 3 shows interface loopback enabled
// (R19) bit 2 shows full duplex
// (R20) bit 1 shows 10 Mbps speed, resets to one
// (R21) bit 0 shows link valid, not cleared by summary read
//
// Decided for this implementation: register access over Wishbone.
`default_nettype none
module pss_regs
    import pss_pkg::*;
#(
    parameter int ADR_W = 8
)(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [ADR_W-1:0]  wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    // extended register space access
    output logic      [4:0]        mmd_dev_out,
    output logic      [15:0]       mmd_addr_out,
    output logic      [15:0]       mmd_wdata_out,
    output logic                   mmd_wr_out,
    input  wire logic [15:0]       mmd_rdata_in,
    // fast link drop events
    input  wire logic              fld_desync_in,
    input  wire logic              fld_rxerr_in,
    input  wire logic              fld_mlt3_in,
    input  wire logic              fld_snr_in,
    input  wire logic              fld_energy_in,
    // live status sources
    input  wire logic              mdix_in,
    input  wire logic              rx_err_event_in,
    input  wire logic              pol_inverted_in,
    input  wire logic              false_carrier_in,
    input  wire logic              sig_det_in,
    input  wire logic              desc_lock_in,
    input  wire logic              page_rx_in,
    input  wire logic              irq_pending_in,
    input  wire logic              remote_fault_in,
    input  wire logic              jabber_in,
    input  wire logic              an_done_in,
    input  wire logic              loopback_in,
    input  wire logic              full_duplex_in,
    input  wire logic              speed_10_in,
    input  wire logic              link_in,
    // reads of neighbouring registers
    input  wire logic              rd_rx_err_cnt_in,
    input  wire logic              rd_ten_meg_in,
    input  wire logic              rd_false_carrier_in,
    input  wire logic              rd_autoneg_exp_in,
    input  wire logic              rd_irq_status_in,
    input  wire logic              rd_basic_status_in
);

    // ====================================================================
    // checks
    // the register index is taken from address bits 7..2
    if (ADR_W < 8 || ADR_W > 32)
        $error("pss_regs: ADR_W must lie in 8..32");

    // ====================================================================
    // state
    typedef struct packed {
        logic        ack;
        logic [15:0] dat;
        logic [1:0]  cmd;
        logic [4:0]  sel;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic [4:0]  fld;
        logic        rxerr;
        logic        pol;
        logic        fcar;
        logic        page;
        logic        irq;
        logic        rfault;
        logic        sd_low;
        logic        dl_low;
        logic        mdix;
        logic        jab;
        logic        an;
        logic        loopb;
        logic        duplex;
        logic        speed;
        logic        link;
    } pss_state_t;

    localparam pss_state_t PSS_RESET = '{
        ack: 1'b0, dat: 16'h0000, cmd: PSS_CMD_ADDR, sel: 5'h00,
        addr: PSS_RST_WINDOW, wdata: 16'h0000, wr: 1'b0, fld: PSS_RST_CAUSE,
        rxerr: 1'b0, pol: 1'b0, fcar: 1'b0, page: 1'b0, irq: 1'b0,
        rfault: 1'b0, sd_low: 1'b0, dl_low: 1'b0, mdix: 1'b0, jab: 1'b0,
        an: 1'b0, loopb: 1'b0, duplex: 1'b0, speed: PSS_RST_SPEED, link: 1'b0
    };

    pss_state_t st;
    pss_state_t next_st;

    // ====================================================================
    // decode
    logic [5:0]  idx;
    logic        req;
    logic        fire;
    logic        sel_ok;
    logic        is_data;
    logic        wr_lo;
    logic        wr_hi;
    logic [15:0] summ;
    logic [15:0] cause_word;
    logic [15:0] wdat;
    logic [4:0]  fld_live;

    assign idx     = wb_adr_in[7:2];
    assign req     = wb_cyc_in && wb_stb_in;
    // request taken on the edge that the master sees ack; effects land there
    assign fire    = req && st.ack;
    assign sel_ok  = (st.sel == PSS_SEL_VENDOR) || (st.sel == PSS_SEL_DEV3)
                   || (st.sel == PSS_SEL_DEV7);                              // R03
    assign is_data = (st.cmd != PSS_CMD_ADDR);                               // R01
    assign wr_lo   = wb_sel_in[0];
    assign wr_hi   = wb_sel_in[1];
    assign wdat    = wb_dat_in[15:0];

    assign fld_live = {fld_desync_in, fld_rxerr_in, fld_mlt3_in, fld_snr_in, fld_energy_in};

    always_comb
    begin
        summ = 16'h0000;
        summ[PSS_ST_MDIX]   = st.mdix;                                       // R06
        summ[PSS_ST_RXERR]  = st.rxerr;
        summ[PSS_ST_POL]    = st.pol;
        summ[PSS_ST_FCAR]   = st.fcar;
        summ[PSS_ST_SIGDET] = sig_det_in && !st.sd_low;                      // R10
        summ[PSS_ST_DLOCK]  = desc_lock_in && !st.dl_low;                    // R11
        summ[PSS_ST_PAGE]   = st.page;
        summ[PSS_ST_IRQ]    = st.irq;
        summ[PSS_ST_RFAULT] = st.rfault;
        summ[PSS_ST_JAB]    = st.jab;                                        // R16
        summ[PSS_ST_AN]     = st.an;                                         // R17
        summ[PSS_ST_LOOP]   = st.loopb;                                      // R18
        summ[PSS_ST_DUPLEX] = st.duplex;                                     // R19
        summ[PSS_ST_SPEED]  = st.speed;                                      // R20
        summ[PSS_ST_LINK]   = st.link;                                       // R21
        cause_word = 16'h0000;
        cause_word[PSS_FLD_DESYNC:PSS_FLD_ENERGY] = st.fld;
    end

    // ====================================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.wr = 1'b0;
        // ack rises a cycle after the request and drops right after it was seen
        next_st.ack = req && !st.ack;
        if (req && !st.ack)
        begin
            unique case (idx)
                PSS_IDX_CMD:    next_st.dat = {st.cmd, 9'h000, st.sel};
                PSS_IDX_WINDOW: next_st.dat = !is_data ? st.addr
                                            : (sel_ok ? mmd_rdata_in : 16'h0000);   // R01
                PSS_IDX_CAUSE:  next_st.dat = cause_word;
                PSS_IDX_SUMM:   next_st.dat = summ;
                default:        next_st.dat = 16'h0000;
            endcase
        end

        // live mirrors; speed keeps its reset value until sampled
        next_st.mdix   = mdix_in;                                            // R06
        next_st.jab    = jabber_in;                                          // R16
        next_st.an     = an_done_in;                                         // R17
        next_st.loopb  = loopback_in;                                        // R18
        next_st.duplex = full_duplex_in;                                     // R19
        next_st.speed  = speed_10_in;                                        // R20
        next_st.link   = link_in;                                            // R21

        // read side effects first, so that events below win over clears
        if (fire && !wb_we_in && idx == PSS_IDX_CAUSE)
            next_st.fld = st.fld & fld_live;                                 // R05
        if (fire && !wb_we_in && idx == PSS_IDX_SUMM)
        begin
            next_st.sd_low = 1'b0;                                           // R12
            next_st.dl_low = 1'b0;                                           // R12
        end
        if (rd_rx_err_cnt_in)
            next_st.rxerr = 1'b0;                                            // R07
        if (rd_ten_meg_in)
            next_st.pol = 1'b0;                                              // R08
        if (rd_false_carrier_in)
            next_st.fcar = 1'b0;                                             // R09
        if (rd_autoneg_exp_in)
            next_st.page = 1'b0;                                             // R13
        if (rd_irq_status_in)
            next_st.irq = 1'b0;                                              // R14
        if (rd_basic_status_in)
            next_st.rfault = 1'b0;                                           // R15

        next_st.fld = next_st.fld | fld_live;                                // R04
        if (rx_err_event_in)
            next_st.rxerr = 1'b1;                                            // R07
        if (pol_inverted_in)
            next_st.pol = 1'b1;                                              // R08
        if (false_carrier_in)
            next_st.fcar = 1'b1;                                             // R09
        if (!sig_det_in)
            next_st.sd_low = 1'b1;                                           // R12
        if (!desc_lock_in)
            next_st.dl_low = 1'b1;                                           // R12
        if (page_rx_in)
            next_st.page = 1'b1;                                             // R13
        if (irq_pending_in)
            next_st.irq = 1'b1;                                              // R14
        if (remote_fault_in)
            next_st.rfault = 1'b1;                                           // R15

        // register writes
        if (fire && wb_we_in && idx == PSS_IDX_CMD)
        begin
            if (wr_lo)
                next_st.sel = wdat[PSS_SEL_MSB:0];
            if (wr_hi)
                next_st.cmd = wdat[PSS_CMD_MSB:PSS_CMD_LSB];                 // R02
        end
        if (fire && idx == PSS_IDX_WINDOW && sel_ok)                         // R03
        begin
            if (wb_we_in && !is_data)
            begin
                if (wr_lo)
                    next_st.addr[7:0] = wdat[7:0];                           // R01
                if (wr_hi)
                    next_st.addr[15:8] = wdat[15:8];
            end
            else if (wb_we_in)
            begin
                // partial lanes keep the target's other byte from its read data
                next_st.wdata = {wr_hi ? wdat[15:8] : mmd_rdata_in[15:8],
                                 wr_lo ? wdat[7:0]  : mmd_rdata_in[7:0]};
                next_st.wr = 1'b1;
            end
            // increment waits a cycle behind a write so the strobe hits the old address
            if (st.cmd == PSS_CMD_INC_RW && !wb_we_in)
                next_st.addr = st.addr + 16'h0001;                           // R02
        end
        if (st.wr && (st.cmd == PSS_CMD_INC_RW || st.cmd == PSS_CMD_INC_WR))
            next_st.addr = st.addr + 16'h0001;                               // R02
    end

    // ====================================================================
    // registers
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            st <= PSS_RESET;
        else
            st <= next_st;
    end

    // ====================================================================
    // outputs
    assign wb_ack_out    = st.ack;
    assign wb_dat_out    = {16'h0000, st.dat};
    assign mmd_dev_out   = st.sel;
    assign mmd_addr_out  = st.addr;
    assign mmd_wdata_out = st.wdata;
    assign mmd_wr_out    = st.wr;

endmodule
`default_nettype wire

// >>> bench/pss_regs_assertions.sv
`default_nettype none
module pss_regs_chk
    import pss_pkg::*;
#(
    parameter int ADR_W = 8
)(
    // clock and bus
    input wire logic             ref_clk_in,
    input wire logic             rst_in,
    input wire logic             wb_cyc_in,
    input wire logic             wb_stb_in,
    input wire logic             wb_we_in,
    input wire logic [ADR_W-1:0] wb_adr_in,
    input wire logic [3:0]       wb_sel_in,
    input wire logic [31:0]      wb_dat_in,
    input wire logic [31:0]      wb_dat_out,
    input wire logic             wb_ack_out,
    // target side
    input wire logic [4:0]       mmd_dev_out,
    input wire logic [15:0]      mmd_addr_out,
    input wire logic [15:0]      mmd_wdata_out,
    input wire logic             mmd_wr_out,
    // live status
    input wire logic             mdix_in,
    input wire logic             jabber_in,
    input wire logic             an_done_in,
    input wire logic             loopback_in,
    input wire logic             full_duplex_in,
    input wire logic             speed_10_in,
    input wire logic             link_in,
    input wire logic             sig_det_in,
    input wire logic             desc_lock_in
);
    // ====================
    // helpers
    localparam logic [ADR_W-1:0] A_CMD = ADR_W'({PSS_IDX_CMD, 2'b00});
    localparam logic [ADR_W-1:0] A_WIN = ADR_W'({PSS_IDX_WINDOW, 2'b00});
    localparam logic [ADR_W-1:0] A_CAU = ADR_W'({PSS_IDX_CAUSE, 2'b00});
    localparam logic [ADR_W-1:0] A_SUM = ADR_W'({PSS_IDX_SUMM, 2'b00});
    logic [6:0]  live, live_q, live_q2;
    logic [15:0] wdat;
    logic [1:0]  run, cmd;
    logic        req, dev_ok;
    assign live = {mdix_in, jabber_in, an_done_in, loopback_in, full_duplex_in, speed_10_in,
                   link_in};
    assign wdat = wb_dat_in[15:0];
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign dev_ok = mmd_dev_out inside {PSS_SEL_VENDOR, PSS_SEL_DEV3, PSS_SEL_DEV7};
    always_ff @(posedge ref_clk_in)
    begin
        live_q  <= live;
        live_q2 <= live_q;
    end
    // mirrors lag reset release, so reads are trusted only after three edges
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            run <= 2'h0;
            cmd <= PSS_CMD_ADDR;
        end
        else
        begin
            run <= (run == 2'h3) ? run : run + 2'h1;
            if (req && wb_we_in && wb_adr_in == A_CMD && wb_sel_in[1])
                cmd <= wb_dat_in[15:14];
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd(a);
        req && !wb_we_in && wb_adr_in == a;
    endsequence
    sequence s_wr_done(am);
        req && wb_we_in && wb_adr_in == A_WIN && wb_sel_in[1:0] == 2'b11 && dev_ok
        && ((cmd == PSS_CMD_ADDR) == am) ##1 wb_ack_out;
    endsequence
    // ====================
    // checks
    chk_ack_pulse: assert property (
        req |=> wb_ack_out ##1 !wb_ack_out) else $error("ack not one cycle after request");
    chk_mirror_bits: assert property (
        s_rd(A_SUM) ##0 (run == 2'h3 && live == live_q && live_q == live_q2)
        |=> {wb_dat_out[14], wb_dat_out[5:0]} == live) else $error("mirror bits wrong");
    chk_sigdet_low: assert property (
        s_rd(A_SUM) ##0 (run == 2'h3 && !sig_det_in && !$past(sig_det_in))
        |=> !wb_dat_out[PSS_ST_SIGDET]) else $error("signal detect not low");
    chk_lock_low: assert property (
        s_rd(A_SUM) ##0 (run == 2'h3 && !desc_lock_in && !$past(desc_lock_in))
        |=> !wb_dat_out[PSS_ST_DLOCK]) else $error("lock bit not low");
    chk_cause_rsvd: assert property (
        s_rd(A_CAU) |=> wb_dat_out[31:9] == 23'h00_0000 && wb_dat_out[3:0] == 4'h0)
        else $error("cause reserved bits set");
    chk_addr_load: assert property (
        s_wr_done(1'b1) |=> mmd_addr_out == $past(wdat) && !mmd_wr_out)
        else $error("address not loaded");
    chk_data_write: assert property (
        s_wr_done(1'b0) |=> mmd_wr_out && mmd_wdata_out == $past(wdat))
        else $error("target write missing");
    chk_addr_incr: assert property (
        mmd_wr_out && cmd[1] |=> mmd_addr_out == $past(mmd_addr_out) + 16'h0001)
        else $error("address not incremented");
    chk_addr_keep: assert property (
        mmd_wr_out && cmd == PSS_CMD_DATA |=> $stable(mmd_addr_out))
        else $error("address moved");
    chk_sel_guard: assert property (
        mmd_wr_out |-> dev_ok && $past(wb_ack_out)) else $error("stray target write");
    chk_bad_sel_rd: assert property (
        s_rd(A_WIN) ##0 !dev_ok |=> wb_dat_out == 32'h0000_0000)
        else $error("bad selector read not zero");
endmodule
bind pss_regs pss_regs_chk #(.ADR_W(ADR_W)) i_pss_regs_chk (.*);
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench
    import pss_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [6:0] live; logic [15:0] exp; } pss_row_t;
    typedef struct packed { logic [15:0] cmd; logic we; logic [15:0] d, exp, addr; } pss_win_t;
    logic        ref_clk_in = 1'b0;
    logic        rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, mmd_wr_out;
    logic [7:0]  wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic [4:0]  mmd_dev_out, fld;
    logic [15:0] mmd_addr_out, mmd_wdata_out, mmd_rdata_in, rd;
    logic [15:0] wr_data = 16'h0000;
    logic        fld_desync_in, fld_rxerr_in, fld_mlt3_in, fld_snr_in, fld_energy_in;
    logic        mdix_in, jabber_in, an_done_in, loopback_in, full_duplex_in, speed_10_in;
    logic        link_in, sig_det_in, desc_lock_in, rx_err_event_in, pol_inverted_in;
    logic        false_carrier_in, page_rx_in, irq_pending_in, remote_fault_in;
    logic        rd_rx_err_cnt_in, rd_ten_meg_in, rd_false_carrier_in, rd_autoneg_exp_in;
    logic        rd_irq_status_in, rd_basic_status_in;
    logic [6:0]  live;
    logic [5:0]  evt, clr;
    int          errors = 0, total_checks = 0, cycles = 0;
    int          pos [6] = '{6, 7, 8, 11, 12, 13};
    pss_row_t    rows [8] = '{'{7'h02, 16'h0602}, '{7'h40, 16'h4600}, '{7'h20, 16'h0620},
        '{7'h10, 16'h0610}, '{7'h08, 16'h0608}, '{7'h04, 16'h0604}, '{7'h01, 16'h0601},
        '{7'h7F, 16'h463F}};
    pss_win_t    win [10] = '{'{16'h001F, 1'b1, 16'h0123, 16'h0000, 16'h0123},
        '{16'h801F, 1'b1, 16'hBEEF, 16'hBEEF, 16'h0124},
        '{16'h801F, 1'b0, 16'h0000, 16'h5B7E, 16'h0125},
        '{16'hC01F, 1'b0, 16'h0000, 16'h5B7F, 16'h0125},
        '{16'hC01F, 1'b1, 16'h1111, 16'h1111, 16'h0126},
        '{16'h401F, 1'b1, 16'h2222, 16'h2222, 16'h0126},
        '{16'h4003, 1'b0, 16'h0000, 16'h5B7C, 16'h0126},
        '{16'h4007, 1'b0, 16'h0000, 16'h5B7C, 16'h0126},
        '{16'h4005, 1'b0, 16'h0000, 16'h0000, 16'h0126},
        '{16'h4005, 1'b1, 16'h3333, 16'h2222, 16'h0126}};
    assign {fld_desync_in, fld_rxerr_in, fld_mlt3_in, fld_snr_in, fld_energy_in} = fld;
    assign {mdix_in, jabber_in, an_done_in, loopback_in, full_duplex_in, speed_10_in,
            link_in} = live;
    assign {rx_err_event_in, pol_inverted_in, false_carrier_in, page_rx_in, irq_pending_in,
            remote_fault_in} = evt;
    assign {rd_rx_err_cnt_in, rd_ten_meg_in, rd_false_carrier_in, rd_autoneg_exp_in,
            rd_irq_status_in, rd_basic_status_in} = clr;
    // target data depends on the address so a wrong address shows up in the read
    assign mmd_rdata_in = mmd_addr_out ^ 16'h5A5A;
    pss_regs #(.ADR_W(8)) i_pss_regs (.*);
    always #4 ref_clk_in = ~ref_clk_in;
    // ====================
    // tasks
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (mmd_wr_out === 1'b1)
            wr_data <= mmd_wdata_out;
        if (cycles == 5000)
        begin
            errors = errors + 1;
            summarize();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h got %h", name, exp, got);
        end
    endtask
    // three idle edges keep the minimum request spacing
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
        repeat (3) @(posedge ref_clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, 16'h0000, d};
        do
            @(posedge ref_clk_in);
        while (wb_ack_out !== 1'b1);
        rd = wb_dat_out[15:0];
        {wb_cyc_in, wb_stb_in} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string name);
        xfer(a, 1'b0, 16'h0000);
        check(name, exp, rd);
    endtask
    // ====================
    // sequence
    initial
    begin
        {rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_sel_in} = {4'b1000, 4'h3};
        {wb_adr_in, wb_dat_in} = {8'h00, 32'h0000_0000};
        {fld, evt, clr, live, sig_det_in, desc_lock_in} = {5'h00, 12'h000, 7'h02, 2'b11};
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        foreach (rows[i])
        begin
            live <= rows[i].live;
            rdc(8'h40, rows[i].exp, "summary");
        end
        rdc(8'h40, 16'h463F, "summary_again");
        $display("test mirrors done");
        rdc(8'h3C, 16'h0000, "cause_reset");
        rdc(8'h80, 16'h0000, "unmapped");
        xfer(8'h40, 1'b1, 16'hFFFF);
        rdc(8'h40, 16'h463F, "summary_ro");
        for (int i = 0; i < 5; i++)
        begin
            fld[i] <= 1'b1;
            @(posedge ref_clk_in);
            fld[i] <= 1'b0;
            rdc(8'h3C, 16'h0010 << i, "cause");
            rdc(8'h3C, 16'h0000, "cause_clear");
        end
        fld[0] <= 1'b1;
        rdc(8'h3C, 16'h0010, "cause_held");
        fld[0] <= 1'b0;
        rdc(8'h3C, 16'h0010, "cause_last");
        rdc(8'h3C, 16'h0000, "cause_gone");
        $display("test cause done");
        for (int i = 0; i < 6; i++)
        begin
            evt[i] <= 1'b1;
            @(posedge ref_clk_in);
            evt[i] <= 1'b0;
            rdc(8'h40, 16'h463F | (16'h0001 << pos[i]), "event");
            rdc(8'h40, 16'h463F | (16'h0001 << pos[i]), "event_kept");
            clr[i] <= 1'b1;
            @(posedge ref_clk_in);
            clr[i] <= 1'b0;
            rdc(8'h40, 16'h463F, "event_clear");
        end
        for (int i = 0; i < 2; i++)
        begin
            {sig_det_in, desc_lock_in} <= i ? 2'b10 : 2'b01;
            rdc(8'h40, i ? 16'h443F : 16'h423F, "latch_low");
            {sig_det_in, desc_lock_in} <= 2'b11;
            rdc(8'h40, i ? 16'h443F : 16'h423F, "latch_low_held");
            rdc(8'h40, 16'h463F, "latch_low_back");
        end
        $display("test status done");
        foreach (win[i])
        begin
            xfer(8'h34, 1'b1, win[i].cmd);
            xfer(8'h38, win[i].we, win[i].d);
            repeat (3) @(posedge ref_clk_in);
            check("window", win[i].exp, win[i].we ? wr_data : rd);
            check("target_addr", win[i].addr, mmd_addr_out);
            check("selector", {11'h000, win[i].cmd[4:0]}, {11'h000, mmd_dev_out});
        end
        $display("test window done");
        evt[0] <= 1'b1;
        @(posedge ref_clk_in);
        {evt[0], rst_in} <= 2'b01;
        @(posedge ref_clk_in);
        check("addr_after_reset", 16'h0000, mmd_addr_out);
        rst_in <= 1'b0;
        rdc(8'h40, 16'h463F, "summary_after_reset");
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
